/* File: logic/dcl_distance.sv */
// distance comparator logic: four zones of ground and phase elements,
// memory polarization and an AXI4-Lite register slave
// assumes the phasor inputs come from an estimator on aclk with a
// one-cycle sample_valid strobe at 64 samples per power system cycle
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dcl_map.svh"

// Operation
// - ground right boundary: compensated I*ZR-V against I*ZR, 90 degree limit
// - both resistive boundaries count only for quadrilateral shape
// - left boundary: I*ZL-V against I*ZL, satisfied within 90 degrees
// - ground only: zero-sequence against phase negative-sequence current, 50 degrees
// - fault-type comparator blocks ground elements on double line-to-ground faults
// - ground zones 2-4: I0*ZD against -V0 within 90 degrees
// - circular phase: mho, reactance on reach limit; directional on its limit
// - circular ground adds I0*Z reactance, two directionals, fault-type, zero-sequence
// - quad phase: reactance, directional, right and left boundaries, no mho
// - quad ground: reactance, two directionals, boundaries, fault-type, zero-sequence
// - mho and directional comparators polarize from memorized or actual positive-sequence voltage
// - memory established after five cycles above 80 percent nominal
// - memorized voltage is the positive-sequence voltage three cycles old
// - established memory and drop below 80 percent starts memory timer
// - on expiry use actual voltage above 10 percent, else memory
// - compensation only in reach comparators; sequence directionals uncompensated
// - operate only when all applicable comparators and supervision agree
// - comparator satisfied when absolute angle difference is below its limit
// - comparator inputs refresh at 64 samples per power system cycle
module dcl_distance
  import dcl_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // phasor stream
  input wire logic sample_valid,
  input wire dcl_v1_t v1_in,
  input wire dcl_gnd_in_t gnd_in [4][3],
  input wire dcl_phs_in_t phs_in [4][3],
  // element decisions, bit 3*zone+loop
  output logic [11:0] gnd_operate,
  output logic [11:0] phs_operate,
  output logic mem_use,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // angle comparator: wrapped difference, magnitude strictly below limit
  function automatic logic ang_ok(dcl_ang_t a, dcl_ang_t b, dcl_ang_t lim);
    logic [15:0] d;
    logic [16:0] m;
    d = a - b;
    m = d[15] ? (17'h10000 - {1'b0, d}) : {1'b0, d};
    return m < {1'b0, lim};
  endfunction

  // byte-lane merge for 16-bit settings
  function automatic logic [15:0] merge16(logic [15:0] old,
                                          logic [31:0] wd,
                                          logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ---------------- register slave ----------------
  logic [3:0] shape_r, shape_nxt;
  dcl_ang_t comp_lim_r, comp_lim_nxt;
  dcl_ang_t dir_lim_r, dir_lim_nxt;
  dcl_mag_t pickup_r, pickup_nxt;
  dcl_mag_t nominal_r, nominal_nxt;
  logic [15:0] mem_time_r, mem_time_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic aw_got_r, aw_got_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic w_got_r, w_got_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  dcl_mem_state_t mem_st_r, mem_st_nxt;
  logic [11:0] gnd_op_r, gnd_op_nxt;
  logic [11:0] phs_op_r, phs_op_nxt;
  logic use_mem;

  // each address accepted once; a new one waits for the response to drain
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // write path: address and data may arrive in either order
  always_comb begin
    awaddr_nxt = awaddr_r;
    aw_got_nxt = aw_got_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    w_got_nxt = w_got_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    shape_nxt = shape_r;
    comp_lim_nxt = comp_lim_r;
    dir_lim_nxt = dir_lim_r;
    pickup_nxt = pickup_r;
    nominal_nxt = nominal_r;
    mem_time_nxt = mem_time_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt = s_axi_awaddr;
      aw_got_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      w_got_nxt = 1'b1;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_got_r && w_got_r && !bvalid_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `DCL_RESP_OKAY;
      unique case (awaddr_r)
        `DCL_OFF_CTRL: begin
          if (wstrb_r[0]) begin
            shape_nxt = wdata_r[`DCL_CTRL_SHAPE_LSB +: 4];
          end
        end
        `DCL_OFF_COMP_LIMIT: comp_lim_nxt = merge16(comp_lim_r, wdata_r,
                                                    wstrb_r);
        `DCL_OFF_DIR_LIMIT: dir_lim_nxt = merge16(dir_lim_r, wdata_r,
                                                  wstrb_r);
        `DCL_OFF_PICKUP: pickup_nxt = merge16(pickup_r, wdata_r, wstrb_r);
        `DCL_OFF_NOMINAL: nominal_nxt = merge16(nominal_r, wdata_r,
                                                wstrb_r);
        `DCL_OFF_MEM_TIME: mem_time_nxt = merge16(mem_time_r, wdata_r,
                                                  wstrb_r);
        `DCL_OFF_STATUS, `DCL_OFF_GND_OP, `DCL_OFF_PHS_OP: begin
          // read-only: write ignored, still answered okay
        end
        default: bresp_nxt = `DCL_RESP_SLVERR;
      endcase
    end
  end

  // read path: one cycle from address to data
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `DCL_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        `DCL_OFF_CTRL: rdata_nxt[`DCL_CTRL_SHAPE_LSB +: 4] = shape_r;
        `DCL_OFF_COMP_LIMIT: rdata_nxt[15:0] = comp_lim_r;
        `DCL_OFF_DIR_LIMIT: rdata_nxt[15:0] = dir_lim_r;
        `DCL_OFF_PICKUP: rdata_nxt[15:0] = pickup_r;
        `DCL_OFF_NOMINAL: rdata_nxt[15:0] = nominal_r;
        `DCL_OFF_MEM_TIME: rdata_nxt[15:0] = mem_time_r;
        `DCL_OFF_STATUS: begin
          rdata_nxt[`DCL_STAT_STATE_LSB +: 2] = mem_st_r;
          rdata_nxt[`DCL_STAT_USE_MEM_BIT] = use_mem;
        end
        `DCL_OFF_GND_OP: rdata_nxt[11:0] = gnd_op_r;
        `DCL_OFF_PHS_OP: rdata_nxt[11:0] = phs_op_r;
        default: rresp_nxt = `DCL_RESP_SLVERR;
      endcase
    end
  end

  // bus and settings registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= 8'h00;
      aw_got_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `DCL_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `DCL_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      shape_r <= `DCL_RST_CTRL;
      comp_lim_r <= `DCL_RST_COMP_LIMIT;
      dir_lim_r <= `DCL_RST_DIR_LIMIT;
      pickup_r <= `DCL_RST_PICKUP;
      nominal_r <= `DCL_RST_NOMINAL;
      mem_time_r <= `DCL_RST_MEM_TIME;
    end else begin
      awaddr_r <= awaddr_nxt;
      aw_got_r <= aw_got_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      w_got_r <= w_got_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      shape_r <= shape_nxt;
      comp_lim_r <= comp_lim_nxt;
      dir_lim_r <= dir_lim_nxt;
      pickup_r <= pickup_nxt;
      nominal_r <= nominal_nxt;
      mem_time_r <= mem_time_nxt;
    end
  end

  // ---------------- memory polarization ----------------
  localparam int DELAY_N = `DCL_DELAY_SAMPLES;
  dcl_ang_t delay_mem [DELAY_N];
  logic [7:0] wptr_r, wptr_nxt;
  dcl_ang_t mem_ang_r, mem_ang_nxt;
  logic [8:0] est_cnt_r, est_cnt_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic above_est, above_act, dl_write;

  // thresholds by cross-multiplying, so no divider is needed
  assign above_est = (19'(v1_in.mag) * 19'(`DCL_EST_DEN))
                   > (19'(nominal_r) * 19'(`DCL_EST_NUM));
  assign above_act = (20'(v1_in.mag) * 20'(`DCL_ACT_DEN))
                   > (20'(nominal_r) * 20'(`DCL_ACT_NUM));
  // memory freezes during the hold and after expiry at low voltage,
  // keeping the pre-fault angle rather than the faulted one
  assign dl_write = sample_valid && above_est && (mem_st_r != MEM_HOLD);

  always_comb begin
    mem_st_nxt = mem_st_r;
    est_cnt_nxt = est_cnt_r;
    tmr_nxt = tmr_r;
    wptr_nxt = wptr_r;
    mem_ang_nxt = mem_ang_r;
    if (dl_write) begin
      mem_ang_nxt = delay_mem[wptr_r];
      wptr_nxt = (wptr_r == 8'(DELAY_N - 1)) ? 8'h00 : wptr_r + 8'h01;
    end
    if (sample_valid) begin
      unique case (mem_st_r)
        MEM_IDLE, MEM_EXPIRED: begin
          if (!above_est) begin
            est_cnt_nxt = 9'h000;
          end else if (est_cnt_r == 9'(`DCL_EST_SAMPLES - 1)) begin
            est_cnt_nxt = 9'h000;
            mem_st_nxt = MEM_READY;
          end else begin
            est_cnt_nxt = est_cnt_r + 9'h001;
          end
        end
        MEM_READY: begin
          if (!above_est) begin
            tmr_nxt = 16'h0000;
            mem_st_nxt = MEM_HOLD;
          end
        end
        MEM_HOLD: begin
          if (tmr_r + 16'h0001 >= mem_time_r) begin
            mem_st_nxt = MEM_EXPIRED;
          end else begin
            tmr_nxt = tmr_r + 16'h0001;
          end
        end
      endcase
    end
  end

  // polarizing source: memory while established or held, actual after
  // expiry only if the live voltage is still worth trusting
  always_comb begin
    unique case (mem_st_r)
      MEM_IDLE: use_mem = 1'b0;
      MEM_READY, MEM_HOLD: use_mem = 1'b1;
      MEM_EXPIRED: use_mem = !above_act;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_st_r <= MEM_IDLE;
      est_cnt_r <= 9'h000;
      tmr_r <= 16'h0000;
      wptr_r <= 8'h00;
      mem_ang_r <= 16'h0000;
    end else begin
      mem_st_r <= mem_st_nxt;
      est_cnt_r <= est_cnt_nxt;
      tmr_r <= tmr_nxt;
      wptr_r <= wptr_nxt;
      mem_ang_r <= mem_ang_nxt;
    end
  end

  // delay line storage, no reset needed: it fills before use
  always_ff @(posedge aclk) begin
    if (dl_write) begin
      delay_mem[wptr_r] <= v1_in.ang;
    end
  end

  // ---------------- elements ----------------
  dcl_ang_t pol_base;
  logic [33:0] pk_sq3;
  assign pol_base = use_mem ? mem_ang_r : v1_in.ang;
  // phase supervision |I|/root3 > P rewritten as |I|^2 > 3 P^2
  assign pk_sq3 = 34'(pickup_r) * 34'(pickup_r) * 34'd3;

  // rotation of phase A positive sequence to each loop (ABC rotation)
  localparam dcl_ang_t GROT [3] = '{16'h0000, 16'h0000 - `DCL_ANG_120,
                                    `DCL_ANG_120};
  localparam dcl_ang_t PROT [3] = '{`DCL_ANG_30, 16'h0000 - `DCL_ANG_90,
                                    `DCL_ANG_150};

  genvar z, k;
  generate
    for (z = 0; z < 4; z++) begin : g_zone
      for (k = 0; k < 3; k++) begin : g_loop
        dcl_gnd_in_t g;
        dcl_phs_in_t p;
        dcl_ang_t gpol, ppol;
        logic g_mho, g_re, g_d0, g_d2, g_rb, g_lb, g_ft, g_zs, g_oc;
        logic p_mho, p_re, p_d, p_rb, p_lb, p_oc, quad;
        assign g = gnd_in[z][k];
        assign p = phs_in[z][k];
        assign gpol = pol_base + GROT[k];
        assign ppol = pol_base + PROT[k];
        assign quad = shape_r[z];
        // ground comparators: reach ones on compensated loop quantities,
        // directionals on the raw sequence currents
        assign g_mho = ang_ok(g.op, gpol, comp_lim_r);
        assign g_re = ang_ok(g.op, g.i0z, comp_lim_r);
        assign g_d0 = ang_ok(g.i0zd, gpol, dir_lim_r);
        assign g_d2 = ang_ok(g.i2zd, gpol, dir_lim_r);
        assign g_rb = ang_ok(g.irv, g.ir, `DCL_ANG_90);
        assign g_lb = ang_ok(g.ilv, g.il, `DCL_ANG_90);
        assign g_ft = ang_ok(g.i0, g.i2, `DCL_ANG_50);
        // zone 1 has no zero-sequence directional check
        assign g_zs = (z == 0) || ang_ok(g.i0zd, g.neg_v0,
                                         `DCL_ANG_90);
        assign g_oc = (18'(g.i0_mag) * 18'd3) > 18'(pickup_r);
        // phase comparators
        assign p_mho = ang_ok(p.op, ppol, comp_lim_r);
        assign p_re = ang_ok(p.op, p.iz, comp_lim_r);
        assign p_d = ang_ok(p.izd, ppol, dir_lim_r);
        assign p_rb = ang_ok(p.irv, p.ir, `DCL_ANG_90);
        assign p_lb = ang_ok(p.ilv, p.il, `DCL_ANG_90);
        assign p_oc = (34'(p.loop_mag) * 34'(p.loop_mag)) > pk_sq3;
        // element decisions: all applicable comparators at once
        always_comb begin
          if (quad) begin
            gnd_op_nxt[3*z+k] = g_re && g_d0 && g_d2 && g_rb && g_lb
                              && g_ft && g_zs && g_oc;
            phs_op_nxt[3*z+k] = p_re && p_d && p_rb && p_lb
                              && p_oc;
          end else begin
            // boundaries are ignored for the circular shape
            gnd_op_nxt[3*z+k] = g_mho && g_re && g_d0 && g_d2
                              && g_ft && g_zs && g_oc;
            phs_op_nxt[3*z+k] = p_mho && p_re && p_d && p_oc;
          end
        end
      end
    end
  endgenerate

  // decisions refresh once per sample; a fault-type miss (g_ft low) holds
  // the ground element off, which is how double-ground faults are blocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gnd_op_r <= 12'h000;
      phs_op_r <= 12'h000;
    end else if (sample_valid) begin
      gnd_op_r <= gnd_op_nxt;
      phs_op_r <= phs_op_nxt;
    end
  end

  assign gnd_operate = gnd_op_r;
  assign phs_operate = phs_op_r;
  assign mem_use = use_mem;

endmodule

/* File: logic/dcl_map.svh */
// register offsets, field positions, reset values and counts for the
// distance comparator block; included by the package user module only
`ifndef DCL_MAP_SVH
`define DCL_MAP_SVH

// register byte offsets on the 32-bit register bus
`define DCL_OFF_CTRL 8'h00
`define DCL_OFF_COMP_LIMIT 8'h04
`define DCL_OFF_DIR_LIMIT 8'h08
`define DCL_OFF_PICKUP 8'h0c
`define DCL_OFF_NOMINAL 8'h10
`define DCL_OFF_MEM_TIME 8'h14
`define DCL_OFF_STATUS 8'h18
`define DCL_OFF_GND_OP 8'h1c
`define DCL_OFF_PHS_OP 8'h20

// field positions
`define DCL_CTRL_SHAPE_LSB 0
`define DCL_STAT_STATE_LSB 0
`define DCL_STAT_USE_MEM_BIT 2

// reset values
`define DCL_RST_CTRL 4'h0
`define DCL_RST_COMP_LIMIT 16'h3555
`define DCL_RST_DIR_LIMIT 16'h3555
`define DCL_RST_PICKUP 16'h0100
`define DCL_RST_NOMINAL 16'h1000
`define DCL_RST_MEM_TIME 16'h0400

// angles: full circle is 65536 units
`define DCL_ANG_90 16'h4000
`define DCL_ANG_50 16'h238e
`define DCL_ANG_30 16'h1555
`define DCL_ANG_120 16'h5555
`define DCL_ANG_150 16'h6aab

// sampling counts, in power system cycles and in samples of the phasor stream
`define DCL_SAMPLES_PER_CYCLE 64
`define DCL_EST_CYCLES 5
`define DCL_DELAY_CYCLES 3
`define DCL_EST_SAMPLES (`DCL_EST_CYCLES * `DCL_SAMPLES_PER_CYCLE)
`define DCL_DELAY_SAMPLES (`DCL_DELAY_CYCLES * `DCL_SAMPLES_PER_CYCLE)

// voltage thresholds as fractions num/den of nominal
`define DCL_EST_NUM 4
`define DCL_EST_DEN 5
`define DCL_ACT_NUM 1
`define DCL_ACT_DEN 10

// bus answers
`define DCL_RESP_OKAY 2'b00
`define DCL_RESP_SLVERR 2'b10

`endif

/* File: logic/dcl_pkg.sv */
// types shared by the distance comparator block and its bench
// assumes angles are 16-bit two's complement fractions of a full turn
package dcl_pkg;

  typedef logic [15:0] dcl_ang_t;
  typedef logic [15:0] dcl_mag_t;

  // one ground loop of one zone; loop quantities are already compensated
  typedef struct packed {
    dcl_ang_t op;      // I*Z + comp - V
    dcl_ang_t i0z;     // I0*Z, reactance reference
    dcl_ang_t i0zd;    // I0*ZD, uncompensated
    dcl_ang_t i2zd;    // I2*ZD, uncompensated
    dcl_ang_t irv;     // compensated I*ZR - V
    dcl_ang_t ir;      // compensated I*ZR
    dcl_ang_t ilv;     // compensated I*ZL - V
    dcl_ang_t il;      // compensated I*ZL
    dcl_ang_t i0;      // zero-sequence current
    dcl_ang_t i2;      // this phase's negative-sequence current
    dcl_ang_t neg_v0;  // negated zero-sequence voltage
    dcl_mag_t i0_mag;  // |I0|
  } dcl_gnd_in_t;

  // one phase loop of one zone
  typedef struct packed {
    dcl_ang_t op;
    dcl_ang_t iz;
    dcl_ang_t izd;
    dcl_ang_t irv;
    dcl_ang_t ir;
    dcl_ang_t ilv;
    dcl_ang_t il;
    dcl_mag_t loop_mag;
  } dcl_phs_in_t;

  // positive-sequence voltage of phase A
  typedef struct packed {
    dcl_ang_t ang;
    dcl_mag_t mag;
  } dcl_v1_t;

  typedef enum logic [1:0] {
    MEM_IDLE = 2'b00,
    MEM_READY = 2'b01,
    MEM_HOLD = 2'b10,
    MEM_EXPIRED = 2'b11
  } dcl_mem_state_t;

endpackage

/* File: tb/dcl_distance_assertions.sv */
// concurrent checks on the distance comparator ports
// assumes one aclk domain and binding onto dcl_distance
`timescale 1ns/1ps
module dcl_distance_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // element side
  input wire logic sample_valid,
  input wire logic [11:0] gnd_operate,
  input wire logic [11:0] phs_operate,
  input wire logic mem_use,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // decisions only move when a phasor sample arrives
  a_op_on_sample: assert property (
    !sample_valid |=> $stable(gnd_operate) && $stable(phs_operate))
    else $error("operate changed without a sample");
  // leaving reset: no trip and no memory in use
  a_reset_idle: assert property (
    $rose(aresetn) |-> !mem_use && gnd_operate == 12'h000 &&
      phs_operate == 12'h000)
    else $error("outputs not idle after reset");
  // answers stand until taken
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  // one transfer of each kind at a time
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // answers come promptly
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20 |-> ##[1:2]
    s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind dcl_distance dcl_distance_assertions i_dcl_distance_assertions (
  .aclk, .aresetn, .sample_valid, .gnd_operate, .phs_operate, .mem_use,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);

/* File: tb/tb_dcl_distance.sv */
// self-checking bench for the distance comparator block
// assumes the checker file binds itself onto the design
`timescale 1ns/1ps
module tb_dcl_distance;
  import dcl_pkg::*;
  localparam logic [3:0] QUAD = 4'ha; // zones 2 and 4 quadrilateral
  // stimulus and observed signals
  logic aclk = 1'b0, aresetn = 1'b0, sample_valid = 1'b0;
  dcl_v1_t v1_in = '0;
  dcl_gnd_in_t gnd_in [4][3];
  dcl_phs_in_t phs_in [4][3];
  logic [11:0] gnd_operate, phs_operate;
  logic mem_use, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, s_axi_wdata = 32'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  int error_cnt = 0, n_checks = 0;
  logic [15:0] pol = 16'h0000;
  // per-loop polarizing rotation, ground then phase loops
  logic [15:0] rg [3] = '{16'h0000, 16'haaab, 16'h5555};
  logic [15:0] rp [3] = '{16'h1555, 16'hc000, 16'h6aab};
  logic [31:0] rst_val [6] = '{32'h0, 32'h3555, 32'h3555, 32'h100,
                               32'h1000, 32'h400};

  always #20 aclk = ~aclk;

  dcl_distance i_dcl_distance (.*);

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // a wait that ran out ends the run as a failure
  task automatic bound(int n);
    if (n >= 50) begin
      error_cnt++;
      complete_run();
    end
  endtask

  // answer ready goes up with the request and stays until the answer;
  // one idle edge at the end keeps the next call off the same time step
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    bound(n);
    chk("bresp", s_axi_bresp, er);
    @(posedge aclk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    bound(n);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
    @(posedge aclk);
  endtask

  task automatic smp(int n);
    repeat (n) begin
      sample_valid <= 1'b1;
      @(posedge aclk);
    end
    sample_valid <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic [15:0] brk(int f);
    return (f == 0) ? 16'hfe00 : 16'h8000;
  endfunction

  // all loops aligned on the polarizing angle, loop b of one side
  // disturbed in field f; cls 0 all zones, 1 quad, 2 zones 2-4, 3 none
  task automatic run(bit g, int f, logic [15:0] d, int cls);
    logic [11:0][15:0] gv;
    logic [7:0][15:0] pv;
    logic [11:0] m;
    m = 12'hfff;
    for (int z = 0; z < 4; z++)
      for (int k = 0; k < 3; k++) begin
        gv = {12{pol + rg[k]}};
        pv = {8{pol + rp[k]}};
        gv[0] = 16'h0200;
        pv[0] = 16'h0200;
        if (k == 1 && g) gv[f] = gv[f] + d;
        if (k == 1 && !g) pv[f] = pv[f] + d;
        if (k == 1 && (cls == 0 || (cls == 1 && QUAD[z]) ||
            (cls == 2 && z > 0)))
          m[3 * z + 1] = 1'b0;
        gnd_in[z][k] <= gv;
        phs_in[z][k] <= pv;
      end
    smp(1);
    chk("gnd_operate", gnd_operate, g ? m : 12'hfff);
    chk("phs_operate", phs_operate, g ? 12'hfff : m);
  endtask

  initial begin
    for (int z = 0; z < 4; z++)
      for (int k = 0; k < 3; k++) begin
        gnd_in[z][k] = '0;
        phs_in[z][k] = '0;
      end
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // settings, unmapped and read-only places
    foreach (rst_val[i]) rd(8'(4 * i), rst_val[i], 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    wr(8'h40, 32'h1, 2'b10);
    wr(8'h00, {28'h0, QUAD}, 2'b00);
    wr(8'h14, 32'h4, 2'b00);
    wr(8'h18, 32'hff, 2'b00);
    rd(8'h18, 32'h0, 2'b00);
    rd(8'h00, {28'h0, QUAD}, 2'b00);
    // memory needs exactly five cycles of healthy voltage
    v1_in <= '{16'h0000, 16'h0d00};
    smp(319);
    chk("mem_use", mem_use, 1'b0);
    smp(1);
    chk("mem_use", mem_use, 1'b1);
    rd(8'h18, 32'h5, 2'b00);
    // actual angle turns, memorized one is still the old angle
    v1_in <= '{16'h4000, 16'h0d00};
    run(1'b0, 0, 16'h0, 3);
    rd(8'h1c, 32'hfff, 2'b00);
    rd(8'h20, 32'hfff, 2'b00);
    for (int f = 0; f < 12; f++)
      run(1'b1, f, brk(f),
          (f == 1) ? 2 : int'(f > 3 && f < 8));
    for (int f = 0; f < 8; f++)
      run(1'b0, f, brk(f), int'(f > 0 && f < 5));
    run(1'b1, 3, 16'h238e, 0);
    run(1'b1, 3, 16'h238d, 3);
    run(1'b1, 6, 16'h4000, 1);
    run(1'b1, 6, 16'hc001, 3);
    run(1'b1, 4, 16'h4000, 1);
    run(1'b0, 6, 16'h3555, 0);
    run(1'b0, 6, 16'h3554, 3);
    // voltage sag: memory held for the set time, then actual voltage
    v1_in <= '{16'h4000, 16'h0800};
    smp(4);
    chk("mem_use", mem_use, 1'b1);
    smp(2);
    chk("mem_use", mem_use, 1'b0);
    rd(8'h18, 32'h3, 2'b00);
    pol = 16'h4000;
    run(1'b0, 0, 16'h0, 3);
    v1_in <= '{16'h4000, 16'h0100};
    smp(1);
    chk("mem_use", mem_use, 1'b1);
    complete_run();
  end
endmodule
